// ---- src/acs_params.svh ----
// Constants of the conversion sequencer: pointers, command bits,
// reset values and timing counts.
// Assumes a core clock of ACS_CLK_MHZ megahertz.
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// ----------------------------------------------------------------
// Register pointers
// ----------------------------------------------------------------
`define ACS_PTR_CMD       8'h00
`define ACS_PTR_RESULT    8'h01
`define ACS_PTR_LIM_FIRST 8'h04
`define ACS_PTR_LIM_LAST  8'h1E
`define ACS_PTR_ALERT_A   8'h1F
`define ACS_PTR_ALERT_B   8'h20

// ----------------------------------------------------------------
// Command fields and reset values
// ----------------------------------------------------------------
`define ACS_CMD_AUTO      0
`define ACS_CMD_CLEAR     2
`define ACS_CMD_POL       3
`define ACS_CMD_RESET     16'h0000
`define ACS_UPPER_RESET   12'hFFF
`define ACS_LOWER_RESET   12'h000
`define ACS_HYST_RESET    12'h000
`define ACS_SLAVE_ADDR    7'h20
`define ACS_HOLD_AT       4'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ACS_CLK_MHZ       100
`define ACS_CONV_NS       3000
`define ACS_CONV_CYC      ((`ACS_CONV_NS * `ACS_CLK_MHZ) / 1000)
`define ACS_AUTO_US       50
`define ACS_AUTO_CYC      (`ACS_AUTO_US * `ACS_CLK_MHZ)

`endif

// ---- src/acs_pkg.sv ----
// Types shared by the conversion sequencer modules.
// Assumes acs_params.svh supplies all numeric constants.
package acs_pkg;

  // ----------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ACS_IDLE     = 3'b000,
    ACS_ADDR     = 3'b001,
    ACS_ADDR_ACK = 3'b010,
    ACS_RX       = 3'b011,
    ACS_RX_ACK   = 3'b100,
    ACS_TX       = 3'b101,
    ACS_TX_ACK   = 3'b110
  } acs_bus_e;

  typedef enum logic {
    ACS_CONV_IDLE = 1'b0,
    ACS_CONV_RUN  = 1'b1
  } acs_conv_e;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  chan;
    logic [11:0] data;
  } acs_result_s;

  typedef struct packed {
    logic        done;
    logic [3:0]  chan;
    logic [11:0] data;
  } acs_sample_s;

  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } acs_pins_s;

  typedef struct packed {
    logic [1:0][2:0] sh;
    acs_pins_s       pins;
  } acs_sync_s;

  typedef struct packed {
    acs_bus_e    bst;
    logic [3:0]  bcnt;
    logic [7:0]  shreg;
    logic        rd;
    logic        ackd;
    logic        sda_oe;
    logic        pend;
    logic        stretch;
    logic [7:0]  ptr;
    logic [1:0]  wph;
    logic [7:0]  wmsb;
    logic        rfirst;
    logic        rbyte;
    logic [15:0] rword;
    logic [15:0] cmd;
    logic        pwr_down;
    logic        restart;
    logic [3:0]  cur;
    acs_conv_e   cst;
    logic [15:0] ccnt;
    logic [15:0] acnt;
    logic        cstart;
    acs_result_s res;
    logic        alert;
    logic        mwr;
    logic        mclr;
    logic [7:0]  maddr;
    logic [11:0] mdata;
    acs_sample_s smp;
  } acs_core_s;

endpackage : acs_pkg

// ---- src/acs_pin_sync.sv ----
// Bus pin synchroniser: three flops per pin, level accepted when the
// second and third agree, plus clock edges and start/stop events.
// Assumes raw pin levels from outside the core clock domain.
`timescale 1ns/1ps

module acs_pin_sync (
  input  logic               clk,
  input  logic               srst,
  input  logic               scl_pin,
  input  logic               sda_pin,
  output acs_pkg::acs_pins_s pins
);

  acs_pkg::acs_sync_s q;
  acs_pkg::acs_sync_s next_q;
  logic [1:0]         raw;

  assign raw  = {sda_pin, scl_pin};
  assign pins = q.pins;

  // Shift chains, filtered levels and events
  always_comb
  begin
    logic [1:0] lvl;
    lvl    = {q.pins.sda, q.pins.scl};
    next_q = q;
    for (int i = 0; i < 2; i++)
    begin
      next_q.sh[i] = {q.sh[i][1:0], raw[i]};
      if (q.sh[i][1] == q.sh[i][2])
      begin
        lvl[i] = q.sh[i][1];
      end
    end
    next_q.pins.scl      = lvl[0];
    next_q.pins.sda      = lvl[1];
    next_q.pins.scl_rise = lvl[0] & !q.pins.scl;
    next_q.pins.scl_fall = !lvl[0] & q.pins.scl;
    next_q.pins.start    = q.pins.scl & lvl[0] & q.pins.sda & !lvl[1];
    next_q.pins.stop     = q.pins.scl & lvl[0] & !q.pins.sda & lvl[1];
    if (srst)
    begin
      next_q          = '0;
      next_q.sh       = '1;
      next_q.pins.scl = 1'b1;
      next_q.pins.sda = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    q <= next_q;
  end

endmodule : acs_pin_sync

// ---- src/acs_limit_mon.sv ----
// Limit registers per channel and the alert status bits they drive.
// Assumes one-cycle write and sample strobes from the sequencer core.
`timescale 1ns/1ps
`include "acs_params.svh"

module acs_limit_mon #(
  parameter int unsigned NCH = 9
) (
  input  logic                 clk,
  input  logic                 srst,
  input  logic                 wr,
  input  logic [7:0]           waddr,
  input  logic [11:0]          wdata,
  input  logic [7:0]           raddr,
  output logic [15:0]          rdata,
  input  logic                 clr,
  input  acs_pkg::acs_sample_s smp,
  output logic [15:0]          stat_a,
  output logic [15:0]          stat_b,
  output logic                 any
);

  if (NCH < 1 || NCH > 9)
  begin : g_bad_nch
    $error("acs_limit_mon: NCH must be 1 to 9");
  end

  typedef struct packed {
    logic [3*NCH-1:0][11:0] lim;
    logic [2*NCH-1:0]       st;
  } acs_mon_s;

  acs_mon_s    q;
  acs_mon_s    next_q;
  logic [7:0]  widx;
  logic [7:0]  ridx;
  logic [17:0] st_w;

  assign widx   = waddr - `ACS_PTR_LIM_FIRST;
  assign ridx   = raddr - `ACS_PTR_LIM_FIRST;
  assign st_w   = 18'(q.st);
  assign stat_a = st_w[15:0];
  assign stat_b = {14'h0000, st_w[17:16]};
  assign any    = |q.st;
  assign rdata  = (int'(ridx) < 3 * NCH) ? {4'h0, q.lim[ridx]} : 16'h0000;

  // Limit writes, clear, then compare: a set in the clear cycle wins
  always_comb
  begin
    int          c;
    logic [11:0] hi;
    logic [11:0] lo;
    logic [11:0] hy;
    c      = int'(smp.chan);
    hi     = 12'h000;
    lo     = 12'h000;
    hy     = 12'h000;
    next_q = q;
    if (wr && int'(widx) < 3 * NCH)
    begin
      next_q.lim[widx] = wdata;
    end
    if (clr)
    begin
      next_q.st = '0; // [R25]
    end
    if (smp.done && c < NCH)
    begin
      hi = q.lim[3*c];
      lo = q.lim[3*c+1];
      hy = q.lim[3*c+2];
      if (smp.data > hi)
      begin
        next_q.st[2*c+1] = 1'b1; // [R23]
      end
      else if ({1'b0, smp.data} + {1'b0, hy} <= {1'b0, hi})
      begin
        next_q.st[2*c+1] = 1'b0; // [R24]
      end
      if (smp.data < lo)
      begin
        next_q.st[2*c] = 1'b1; // [R23]
      end
      else if ({1'b0, smp.data} >= {1'b0, lo} + {1'b0, hy})
      begin
        next_q.st[2*c] = 1'b0; // [R24]
      end
    end
    if (srst)
    begin
      next_q.st = '0;
      for (int i = 0; i < 3 * NCH; i++)
      begin
        next_q.lim[i] = (i % 3 == 0) ? `ACS_UPPER_RESET :
                        (i % 3 == 1) ? `ACS_LOWER_RESET : `ACS_HYST_RESET;
      end
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    q <= next_q;
  end

endmodule : acs_limit_mon

// ---- src/acs_sequencer.sv ----
// Converter control: two-wire register port, command and autocycle
// channel sequencing, converter timing, power-down and alert pin.
// Assumes an analog converter that holds ADC_DATA valid at the end of
// ADC_BUSY, and open-drain wires resolved outside from the enables.
//
// Contract
// [R01] Start in partial power-down; stay there while idle.
// [R02] Leave partial power-down when the bus master addresses us.
// [R03] Command register write at pointer 0x00 selects command mode (default).
// [R04] Master points to result register 0x01, then reads to trigger.
// [R05] Conversion ends while channel id bits of first byte shift out.
// [R06] Next command conversion starts only when next result read begins.
// [R07] Acquisition plus conversion takes about 3 us per channel.
// [R08] Command mode steps up through selected channels, wraps to first.
// [R09] Master ends command mode with a final NACK then STOP.
// [R10] STOP in command mode halts, powers down, keeps command register.
// [R11] Reads after a STOP restart at first selected channel.
// [R12] Result is two bytes: id plus 4 MSBs, then 8 LSBs.
// [R13] Top command bits select channels; highest bit is lowest channel.
// [R14] Command rewrite abandons sequence; next is new first channel.
// [R15] Autocycle converts in the background about every 50 us.
// [R16] Autocycle accepts bus access anytime; result holds latest value.
// [R17] Autocycle off at power-up; enabled by bit 0, channels bits 15..7.
// [R18] Autocycle steps up from lowest selected channel and loops.
// [R19] Autocycle compares each result with limits, updates alert status.
// [R20] Limit violation drives alert with polarity from command bit 3.
// [R21] Master clears autocycle before command conversions, may resume.
// [R22] STOP in autocycle does not power down; conversions continue.
// [R23] Alert raised when result above upper or below lower limit.
// [R24] Alert clears only once back inside by the hysteresis value.
// [R25] Writing command bit 2 clears alert output and alert status.
`timescale 1ns/1ps
`include "acs_params.svh"

module acs_sequencer #(
  parameter logic [6:0]  SLAVE_ADDR  = `ACS_SLAVE_ADDR,
  parameter int unsigned AUTO_CYCLES = `ACS_AUTO_CYC
) (
  input  logic        CORE_CLK,
  input  logic        SRST,
  input  logic        SCL_IN,
  output logic        SCL_OUT,
  output logic        SCL_OE,
  input  logic        SDA_IN,
  output logic        SDA_OUT,
  output logic        SDA_OE,
  input  logic [11:0] ADC_DATA,
  output logic [3:0]  ADC_CHANNEL,
  output logic        ADC_START,
  output logic        ADC_BUSY,
  output logic        ADC_POWER_DOWN,
  output logic        ALERT
);

  if (AUTO_CYCLES <= `ACS_CONV_CYC || AUTO_CYCLES > 65536)
  begin : g_bad_auto
    $error("acs_sequencer: AUTO_CYCLES out of range");
  end

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  acs_pkg::acs_core_s q;
  acs_pkg::acs_core_s next_q;
  acs_pkg::acs_pins_s pins;
  logic [8:0]         sel;
  logic               auto_on;
  logic               hold;
  logic [15:0]        word;
  logic [7:0]         tx_byte;
  logic [15:0]        rdw;
  logic [15:0]        mon_rdata;
  logic [15:0]        stat_a;
  logic [15:0]        stat_b;
  logic               mon_any;

  // Lowest selected channel at or above a start index, else lowest
  function automatic logic [3:0] pick(input logic [8:0] s, input logic [3:0] from);
    logic [3:0] low;
    logic [3:0] hit;
    logic       found;
    low   = 4'h0;
    hit   = 4'h0;
    found = 1'b0;
    for (int i = 8; i >= 0; i--)
    begin
      if (s[i])
      begin
        low = 4'(i);
        if (4'(i) >= from)
        begin
          hit   = 4'(i);
          found = 1'b1;
        end
      end
    end
    pick = found ? hit : low;
  endfunction : pick

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  acs_pin_sync u_sync (
    .clk     (CORE_CLK),
    .srst    (SRST),
    .scl_pin (SCL_IN),
    .sda_pin (SDA_IN),
    .pins    (pins)
  );

  acs_limit_mon #(
    .NCH (9)
  ) u_mon (
    .clk    (CORE_CLK),
    .srst   (SRST),
    .wr     (q.mwr),
    .waddr  (q.maddr),
    .wdata  (q.mdata),
    .raddr  (q.ptr),
    .rdata  (mon_rdata),
    .clr    (q.mclr),
    .smp    (q.smp),
    .stat_a (stat_a),
    .stat_b (stat_b),
    .any    (mon_any)
  );

  // ----------------------------------------------------------------
  // Decode and transmit data
  // ----------------------------------------------------------------
  // Bit 15 selects the first channel, bit 7 the temperature channel
  assign sel     = {<<{q.cmd[15:7]}}; // [R13]
  assign auto_on = q.cmd[`ACS_CMD_AUTO]; // [R17]
  // In command mode the clock is stretched after the id bits until the conversion is done
  assign hold    = (q.cst == acs_pkg::ACS_CONV_RUN) && !auto_on; // [R05]
  assign word    = (q.ptr == `ACS_PTR_RESULT && !auto_on) ? q.res : q.rword;
  assign tx_byte = q.rbyte ? word[7:0] : word[15:8]; // [R12]

  // Register read decode, latched at the high byte of each word of a read
  always_comb
  begin
    if (q.ptr == `ACS_PTR_CMD)
    begin
      rdw = q.cmd;
    end
    else if (q.ptr == `ACS_PTR_RESULT)
    begin
      rdw = q.res; // [R16]
    end
    else if (q.ptr >= `ACS_PTR_LIM_FIRST && q.ptr <= `ACS_PTR_LIM_LAST)
    begin
      rdw = mon_rdata;
    end
    else if (q.ptr == `ACS_PTR_ALERT_A)
    begin
      rdw = stat_a;
    end
    else if (q.ptr == `ACS_PTR_ALERT_B)
    begin
      rdw = stat_b;
    end
    else
    begin
      rdw = 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic        tx_go;
    logic        rx_go;
    logic        hit;
    logic        stop_go;
    logic        go;
    logic        adv;
    logic [3:0]  ch;
    logic [15:0] w;
    tx_go   = 1'b0;
    rx_go   = 1'b0;
    hit     = 1'b0;
    stop_go = 1'b0;
    go      = 1'b0;
    adv     = 1'b0;
    ch      = 4'h0;
    w       = {q.wmsb, q.shreg};
    next_q  = q;
    next_q.cstart   = 1'b0;
    next_q.mwr      = 1'b0;
    next_q.mclr     = 1'b0;
    next_q.smp.done = 1'b0;

    // Drive the pending transmit bit one cycle after the clock fall
    if (q.pend)
    begin
      next_q.pend   = 1'b0;
      next_q.sda_oe = !tx_byte[3'h7 - q.bcnt[2:0]]; // [R12]
    end

    // Bus bit engine
    if (pins.start)
    begin
      next_q.bst     = acs_pkg::ACS_ADDR;
      next_q.bcnt    = 4'h0;
      next_q.sda_oe  = 1'b0;
      next_q.pend    = 1'b0;
      next_q.stretch = 1'b0;
    end
    else if (pins.stop)
    begin
      next_q.bst     = acs_pkg::ACS_IDLE;
      next_q.sda_oe  = 1'b0;
      next_q.pend    = 1'b0;
      next_q.stretch = 1'b0;
      stop_go        = 1'b1;
    end
    else
    begin
      case (q.bst)
        acs_pkg::ACS_ADDR, acs_pkg::ACS_RX:
        begin
          if (pins.scl_rise)
          begin
            next_q.shreg = {q.shreg[6:0], pins.sda};
            next_q.bcnt  = q.bcnt + 4'h1;
          end
          else if (pins.scl_fall && q.bcnt == 4'h8)
          begin
            if (q.bst == acs_pkg::ACS_RX)
            begin
              next_q.sda_oe = 1'b1;
              next_q.bst    = acs_pkg::ACS_RX_ACK;
              rx_go         = 1'b1;
            end
            else if (q.shreg[7:1] == SLAVE_ADDR)
            begin
              next_q.sda_oe = 1'b1;
              next_q.rd     = q.shreg[0];
              next_q.bst    = acs_pkg::ACS_ADDR_ACK;
              hit           = 1'b1;
            end
            else
            begin
              next_q.bst = acs_pkg::ACS_IDLE;
            end
          end
        end
        acs_pkg::ACS_ADDR_ACK, acs_pkg::ACS_RX_ACK:
        begin
          if (pins.scl_fall)
          begin
            next_q.sda_oe = 1'b0;
            next_q.bcnt   = 4'h0;
            if (q.bst == acs_pkg::ACS_ADDR_ACK && q.rd)
            begin
              next_q.bst  = acs_pkg::ACS_TX;
              next_q.pend = 1'b1;
              tx_go       = 1'b1;
            end
            else
            begin
              next_q.bst = acs_pkg::ACS_RX;
            end
          end
        end
        acs_pkg::ACS_TX:
        begin
          adv = pins.scl_fall && !(q.bcnt == `ACS_HOLD_AT && hold);
          // Queue the next data bit while SCL is still held low; one cycle later
          // the bit is driven and the clock let go at the same edge
          if (q.stretch && !hold)
          begin
            if (q.bcnt == `ACS_HOLD_AT)
            begin
              next_q.bcnt = q.bcnt + 4'h1;
              next_q.pend = 1'b1; // [R05]
            end
            else
            begin
              next_q.stretch = 1'b0; // [R05]
            end
          end
          else if (adv)
          begin
            next_q.stretch = 1'b0;
            if (q.bcnt == 4'h7)
            begin
              next_q.bcnt   = 4'h8;
              next_q.sda_oe = 1'b0;
              next_q.bst    = acs_pkg::ACS_TX_ACK;
            end
            else
            begin
              next_q.bcnt = q.bcnt + 4'h1;
              next_q.pend = 1'b1;
            end
          end
          else if (pins.scl_fall)
          begin
            next_q.stretch = 1'b1; // [R05]
          end
        end
        acs_pkg::ACS_TX_ACK:
        begin
          if (pins.scl_rise)
          begin
            next_q.ackd = !pins.sda;
          end
          else if (pins.scl_fall)
          begin
            if (q.ackd)
            begin
              next_q.bst  = acs_pkg::ACS_TX;
              next_q.bcnt = 4'h0;
              next_q.pend = 1'b1;
              tx_go       = 1'b1;
            end
            else
            begin
              next_q.bst = acs_pkg::ACS_IDLE; // [R09]
            end
          end
        end
        default:
        begin
          next_q.bst = acs_pkg::ACS_IDLE;
        end
      endcase
    end

    // Addressing wakes the converter and opens a new transaction
    if (hit)
    begin
      next_q.wph      = 2'h0;
      next_q.rfirst   = 1'b1;
      next_q.pwr_down = 1'b0; // [R02]
    end

    // Write bytes: pointer, then high and low data bytes
    if (rx_go)
    begin
      case (q.wph)
        2'h0:
        begin
          next_q.ptr = q.shreg;
          next_q.wph = 2'h1;
        end
        2'h1:
        begin
          next_q.wmsb = q.shreg;
          next_q.wph  = 2'h2;
        end
        default:
        begin
          next_q.wph = 2'h0;
          if (q.ptr == `ACS_PTR_CMD)
          begin
            next_q.cmd     = w; // [R03]
            next_q.restart = 1'b1; // [R14]
            next_q.cst     = acs_pkg::ACS_CONV_IDLE; // [R14]
            next_q.acnt    = 16'h0000;
            next_q.mclr    = w[`ACS_CMD_CLEAR]; // [R25]
          end
          else if (q.ptr >= `ACS_PTR_LIM_FIRST && q.ptr <= `ACS_PTR_LIM_LAST)
          begin
            next_q.mwr   = 1'b1;
            next_q.maddr = q.ptr;
            next_q.mdata = w[11:0];
          end
        end
      endcase
    end

    // Read bytes alternate high then low; a high byte of a command-mode
    // result read starts the next conversion
    if (tx_go)
    begin
      next_q.rbyte  = q.rfirst ? 1'b0 : !q.rbyte; // [R12]
      next_q.rfirst = 1'b0;
      if (!next_q.rbyte)
      begin
        next_q.rword = rdw;
        if (q.ptr == `ACS_PTR_RESULT && !auto_on && |sel)
        begin
          go = 1'b1; // [R06]
        end
      end
    end

    // Converter timing; result and limit sample at the end
    if (q.cst == acs_pkg::ACS_CONV_RUN)
    begin
      next_q.ccnt = q.ccnt + 16'h0001;
      if (q.ccnt == 16'(`ACS_CONV_CYC - 1))
      begin
        next_q.cst      = acs_pkg::ACS_CONV_IDLE; // [R07]
        next_q.res      = {q.cur, ADC_DATA}; // [R16]
        next_q.smp.done = auto_on; // [R19]
        next_q.smp.chan = q.cur;
        next_q.smp.data = ADC_DATA;
      end
    end

    // Background period timer
    if (auto_on)
    begin
      if (q.acnt == 16'(AUTO_CYCLES - 1))
      begin
        next_q.acnt = 16'h0000;
        if (q.cst == acs_pkg::ACS_CONV_IDLE && |sel)
        begin
          go = 1'b1; // [R15]
        end
      end
      else
      begin
        next_q.acnt = q.acnt + 16'h0001;
      end
    end
    else
    begin
      next_q.acnt = 16'h0000;
    end

    // Start a conversion on the next selected channel
    if (go)
    begin
      ch              = pick(sel, q.restart ? 4'h0 : 4'(q.cur + 4'h1)); // [R08] [R18]
      next_q.cur      = ch;
      next_q.restart  = 1'b0;
      next_q.cst      = acs_pkg::ACS_CONV_RUN;
      next_q.ccnt     = 16'h0000;
      next_q.cstart   = 1'b1;
      if (!auto_on)
      begin
        next_q.res.chan = ch; // [R05]
      end
    end

    // STOP ends command mode; autocycle keeps running
    if (stop_go && !auto_on)
    begin
      next_q.cst      = acs_pkg::ACS_CONV_IDLE; // [R10]
      next_q.pwr_down = 1'b1; // [R10]
      next_q.restart  = 1'b1; // [R11]
    end
    if (auto_on)
    begin
      next_q.pwr_down = 1'b0; // [R22]
    end

    // Alert pin level follows the status bits and the polarity bit
    next_q.alert = q.cmd[`ACS_CMD_POL] ? mon_any : !mon_any; // [R20]

    if (SRST)
    begin
      next_q          = '0;
      next_q.cmd      = `ACS_CMD_RESET; // [R17]
      next_q.pwr_down = 1'b1; // [R01]
      next_q.restart  = 1'b1;
      next_q.alert    = 1'b1;
    end
  end

  // State register
  always_ff @(posedge CORE_CLK)
  begin
    q <= next_q;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign SCL_OUT        = 1'b0;
  assign SCL_OE         = q.stretch;
  assign SDA_OUT        = 1'b0;
  assign SDA_OE         = q.sda_oe;
  assign ADC_CHANNEL    = q.cur;
  assign ADC_START      = q.cstart;
  assign ADC_BUSY       = (q.cst == acs_pkg::ACS_CONV_RUN);
  assign ADC_POWER_DOWN = q.pwr_down; // [R01]
  assign ALERT          = q.alert;

endmodule : acs_sequencer

// ---- test/acs_props.sv ----
// Checker of conversion timing and clock stretch.
// Sees acs_sequencer ports only; bound at the foot.
`timescale 1ns/1ps
module acs_props (
  input logic       CORE_CLK,
  input logic       SRST,
  input logic       SCL_OE,
  input logic [3:0] ADC_CHANNEL,
  input logic       ADC_START,
  input logic       ADC_BUSY,
  input logic       ADC_POWER_DOWN
);
  // One clock domain
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SRST);
  // Converter strobes
  property p_go; $rose(ADC_BUSY) |-> ADC_START; endproperty
  a_go: assert property (p_go) else $error("busy w/o start");
  property p_pulse; ADC_START |=> !ADC_START; endproperty
  a_pulse: assert property (p_pulse) else $error("long start");
  property p_hold; ADC_START |-> ADC_BUSY [*8]; endproperty
  a_hold: assert property (p_hold) else $error("short busy");
  property p_wake; ADC_BUSY |-> !ADC_POWER_DOWN; endproperty
  a_wake: assert property (p_wake) else $error("asleep");
  property p_chan; ADC_START |-> ADC_CHANNEL <= 4'h8; endproperty
  a_chan: assert property (p_chan) else $error("bad channel");
  property p_keep; ADC_BUSY && !ADC_START |-> $stable(ADC_CHANNEL); endproperty
  a_keep: assert property (p_keep) else $error("channel moved");
  // Stretch only over a conversion, released as it ends
  property p_str; $rose(SCL_OE) |-> ADC_BUSY; endproperty
  a_str: assert property (p_str) else $error("idle stretch");
  property p_rel; $fell(ADC_BUSY) |-> ##[0:4] !SCL_OE; endproperty
  a_rel: assert property (p_rel) else $error("stretch held");
  // Main scenarios
  c_conv: cover property (ADC_START);
  c_str: cover property ($rose(SCL_OE));
  c_pd: cover property ($rose(ADC_POWER_DOWN));
endmodule : acs_props
bind acs_sequencer acs_props u_props (
  .CORE_CLK(CORE_CLK), .SRST(SRST), .SCL_OE(SCL_OE), .ADC_CHANNEL(ADC_CHANNEL),
  .ADC_START(ADC_START), .ADC_BUSY(ADC_BUSY), .ADC_POWER_DOWN(ADC_POWER_DOWN));

// ---- test/acs_i2c_master.sv ----
// Bus master model: open-drain pulls, 124 ns bit.
// Assumes pulled-up wires resolved by the bench.
`timescale 1ns/1ps
module acs_i2c_master (
  input  logic scl,
  input  logic sda,
  output logic scl_pull = 1'b0,
  output logic sda_pull = 1'b0
);
  // One bit; waits out a clock stretch
  task automatic bitx(input logic b, output logic q);
    sda_pull = !b;
    #31;
    scl_pull = 1'b0;
    wait (scl);
    #62;
    q = sda;
    scl_pull = 1'b1;
    #31;
  endtask : bitx
  // Start from idle
  task automatic start();
    sda_pull = 1'b0;
    #31;
    scl_pull = 1'b0;
    #62;
    sda_pull = 1'b1;
    #62;
    scl_pull = 1'b1;
    #31;
  endtask : start
  // Stop, bus left idle
  task automatic stop();
    sda_pull = 1'b1;
    #31;
    scl_pull = 1'b0;
    #62;
    sda_pull = 1'b0;
    #62;
  endtask : stop
  // Byte out and in, then ack bit a
  task automatic xfer(input logic [7:0] w, input logic a,
                      output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--)
      bitx(w[i], q[i]);
    bitx(a, k);
  endtask : xfer
endmodule : acs_i2c_master

// ---- test/tb_acs_sequencer.sv ----
// Bench: command reads, autocycle, alert.
// Uses acs_i2c_master as bus master.
`timescale 1ns/1ps
module tb_acs_sequencer;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [11:0] adc = 12'hA5C;
  logic        soe, doe, spl, dpl, pd, alert, k;
  logic [15:0] v;
  logic [7:0]  r;
  int          error_cnt = 0;
  int          cmp_count = 0;
  wire         scl = !(soe | spl);
  wire         sda = !(doe | dpl);
  acs_sequencer #(.AUTO_CYCLES(400)) DUT (
    .CORE_CLK(clk), .SRST(srst), .SCL_IN(scl), .SCL_OUT(), .SCL_OE(soe),
    .SDA_IN(sda), .SDA_OUT(), .SDA_OE(doe), .ADC_DATA(adc), .ADC_CHANNEL(),
    .ADC_START(), .ADC_BUSY(), .ADC_POWER_DOWN(pd), .ALERT(alert));
  acs_i2c_master m (.scl(scl), .sda(sda), .scl_pull(spl), .sda_pull(dpl));
  always #5 clk = ~clk;
  task automatic chk(input logic [15:0] got, exp, input string n);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, exp, got);
    end
  endtask : chk
  task automatic give_verdict();
    if (error_cnt == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  // Address byte, then pointer when writing
  task automatic adr(input logic rd, input logic [7:0] p);
    m.start();
    m.xfer({7'h20, rd}, 1'b1, r, k);
    chk(16'(k), 16'h0, "ack");
    if (!rd)
      m.xfer(p, 1'b1, r, k);
  endtask : adr
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    adr(1'b0, p);
    m.xfer(d[15:8], 1'b1, r, k);
    m.xfer(d[7:0], 1'b1, r, k);
    m.stop();
  endtask : wr
  // One word; a is the ack of its second byte
  task automatic rdw(input logic a);
    m.xfer(8'hFF, 1'b0, v[15:8], k);
    m.xfer(8'hFF, a, v[7:0], k);
  endtask : rdw
  task automatic rd1(input logic [7:0] p);
    adr(1'b0, p);
    m.stop();
    adr(1'b1, p);
    rdw(1'b1);
    m.stop();
  endtask : rd1
  // Main sequence
  initial
  begin
    repeat (10) @(negedge clk);
    srst = 1'b0;
    repeat (6) @(negedge clk);
    chk(16'(pd), 16'h1, "pd");
    wr(8'h00, 16'hE020);
    adr(1'b0, 8'h01);
    m.stop();
    adr(1'b1, 8'h01);
    @(negedge clk) chk(16'(pd), 16'h0, "pd");
    for (int i = 0; i < 4; i++)
    begin
      rdw(i == 3);
      chk(v, {4'(i % 3), 12'hA5C}, "res");
    end
    m.stop();
    repeat (9) @(negedge clk);
    chk(16'(pd), 16'h1, "pd");
    rd1(8'h00);
    chk(v, 16'hE020, "cmd");
    rd1(8'h01);
    chk(v, 16'h0A5C, "res");
    wr(8'h00, 16'h6020);
    rd1(8'h01);
    chk(v, 16'h1A5C, "res");
    wr(8'h04, 16'h0100);
    wr(8'h00, 16'h8009);
    repeat (1000) @(negedge clk);
    chk(16'(alert), 16'h1, "alert");
    chk(16'(pd), 16'h0, "pd");
    rd1(8'h01);
    chk(v, 16'h0A5C, "res");
    rd1(8'h1F);
    chk(v, 16'h0002, "stat");
    wr(8'h00, 16'h800D);
    @(negedge clk) chk(16'(alert), 16'h0, "alert");
    give_verdict();
  end
  // Watchdog
  initial
  begin
    #900000;
    error_cnt++;
    give_verdict();
  end
endmodule : tb_acs_sequencer
